// *** logic/pfm_port0_low_mux.sv ***
// Design: function selector and pin multiplexer for port-zero lines 0..15
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module pfm_port0_low_mux
  import pfm_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  // Register port
  input  wire logic [31:0]   addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [31:0]   rdata_o,
  // General purpose I/O side
  input  wire logic [15:0]   gpio_out_i,
  input  wire logic [15:0]   line_direction_control_i,
  output logic      [15:0]   gpio_in_o,
  // Peripheral side
  input  wire pfm_drive_type periph_drive_i,
  output pfm_sense_type      periph_sense_o,
  // Pads
  input  wire logic [15:0]   pad_in_i,
  output logic      [15:0]   pad_out_o,
  output logic      [15:0]   pad_oe_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // True when the given line's field holds the given code
  function automatic logic routed(input logic [31:0] sel,
                                  input logic [3:0]  line,
                                  input logic [1:0]  code);
    routed = (sel[{line, 1'b0} +: PFM_FIELD_W] == code);
  endfunction

  // Output level and enable of one pad, bit 1 is level, bit 0 enable
  function automatic logic [1:0] line_drive(input logic [3:0]    line,
                                            input logic [1:0]    code,
                                            input logic          gout,
                                            input logic          gdir,
                                            input pfm_drive_type d);
    logic o;
    logic e;
    o = 1'b0;
    e = 1'b0;
    if (code == PFM_FUNC_GPIO) begin
      o = gout;
      e = gdir;
    end else begin
      case ({line, code})
        {4'h0, PFM_FUNC_ALT1}: begin o = d.serial_a_transmit; e = 1'b1; end
        {4'h0, PFM_FUNC_ALT2}: begin o = d.pulse_out_1; e = 1'b1; end
        {4'h1, PFM_FUNC_ALT2}: begin o = d.pulse_out_3; e = 1'b1; end
        {4'h2, PFM_FUNC_ALT1}: begin o = d.i2c_scl_out; e = d.i2c_scl_oe; end
        {4'h3, PFM_FUNC_ALT1}: begin o = d.i2c_sda_out; e = d.i2c_sda_oe; end
        {4'h3, PFM_FUNC_ALT2}: begin o = d.timer0_match_0; e = 1'b1; end
        {4'h4, PFM_FUNC_ALT1}: begin
          o = d.spi_a_sck_out;
          e = d.spi_a_sck_oe;
        end
        {4'h5, PFM_FUNC_ALT1}: begin
          o = d.spi_a_miso_out;
          e = d.spi_a_miso_oe;
        end
        {4'h5, PFM_FUNC_ALT2}: begin o = d.timer0_match_1; e = 1'b1; end
        {4'h6, PFM_FUNC_ALT1}: begin
          o = d.spi_a_mosi_out;
          e = d.spi_a_mosi_oe;
        end
        {4'h7, PFM_FUNC_ALT1}: begin
          o = d.spi_a_ssel_out;
          e = d.spi_a_ssel_oe;
        end
        {4'h7, PFM_FUNC_ALT2}: begin o = d.pulse_out_2; e = 1'b1; end
        {4'h8, PFM_FUNC_ALT1}: begin o = d.serial_b_transmit; e = 1'b1; end
        {4'h8, PFM_FUNC_ALT2}: begin o = d.pulse_out_4; e = 1'b1; end
        {4'h9, PFM_FUNC_ALT2}: begin o = d.pulse_out_6; e = 1'b1; end
        {4'ha, PFM_FUNC_ALT1}: begin
          o = d.serial_b_request_to_send;
          e = 1'b1;
        end
        {4'hc, PFM_FUNC_ALT2}: begin o = d.timer1_match_0; e = 1'b1; end
        {4'hd, PFM_FUNC_ALT1}: begin
          o = d.serial_b_terminal_ready;
          e = 1'b1;
        end
        {4'hd, PFM_FUNC_ALT2}: begin o = d.timer1_match_1; e = 1'b1; end
        // Input functions and reserved codes leave the pad undriven
        default: begin
          o = 1'b0;
          e = 1'b0;
        end
      endcase
    end
    line_drive = {o, e};
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  pfm_state_type state_reg;
  pfm_state_type state_next;

  logic [31:0] sel_n;
  logic [15:0] p;
  logic [1:0]  drv;
  logic        hit;

  always_comb begin
    state_next = state_reg;
    sel_n      = state_reg.select_reg;
    p          = state_reg.pad_sync_reg;
    drv        = 2'h0;
    // full address decode, other addresses ignored
    hit        = (addr_i == PFM_SEL_ADDR);

    if (wr_i && hit) begin
      sel_n = wdata_i;
    end
    state_next.select_reg = sel_n;

    // read data for one cycle, zero otherwise
    if (rd_i && hit) begin
      state_next.rdata_reg = state_reg.select_reg;
    end else begin
      state_next.rdata_reg = PFM_READ_IDLE;
    end

    // Pads pass two flops before anything looks at them
    state_next.pad_meta_reg = pad_in_i;
    state_next.pad_sync_reg = state_reg.pad_meta_reg;
    // GPIO reads the pin whatever function is selected
    state_next.gpio_in_reg  = p;

    // fields steer each pad from the value being stored
    for (int i = 0; i < PFM_NUM_LINES; i++) begin
      // each line looks at its own field only
      drv = line_drive(4'(i), sel_n[i*PFM_FIELD_W +: PFM_FIELD_W],
                       gpio_out_i[i], line_direction_control_i[i],
                       periph_drive_i);
      state_next.pad_out_reg[i] = drv[1];
      state_next.pad_oe_reg[i]  = drv[0];
    end

    // inputs of lines 1 to 3
    state_next.sense_reg.serial_a_receive =
      routed(sel_n, 4'h1, PFM_FUNC_ALT1) & p[1];
    state_next.sense_reg.i2c_scl_in =
      routed(sel_n, 4'h2, PFM_FUNC_ALT1) & p[2];
    state_next.sense_reg.timer0_capture_0 =
      routed(sel_n, 4'h2, PFM_FUNC_ALT2) & p[2];
    state_next.sense_reg.i2c_sda_in =
      routed(sel_n, 4'h3, PFM_FUNC_ALT1) & p[3];
    state_next.sense_reg.ext_irq_line_0 =
      routed(sel_n, 4'h1, PFM_FUNC_ALT3) & p[1];
    // irq 1 and 2 may come from two lines, combined
    state_next.sense_reg.ext_irq_line_1 =
      (routed(sel_n, 4'h3, PFM_FUNC_ALT3) & p[3]) |
      (routed(sel_n, 4'he, PFM_FUNC_ALT2) & p[14]);
    state_next.sense_reg.ext_irq_line_2 =
      (routed(sel_n, 4'h7, PFM_FUNC_ALT3) & p[7]) |
      (routed(sel_n, 4'hf, PFM_FUNC_ALT2) & p[15]);
    // inputs of lines 4 and 5
    state_next.sense_reg.spi_a_sck_in =
      routed(sel_n, 4'h4, PFM_FUNC_ALT1) & p[4];
    state_next.sense_reg.timer0_capture_1 =
      routed(sel_n, 4'h4, PFM_FUNC_ALT2) & p[4];
    state_next.sense_reg.spi_a_miso_in =
      routed(sel_n, 4'h5, PFM_FUNC_ALT1) & p[5];
    // inputs of lines 6 and 7
    state_next.sense_reg.spi_a_mosi_in =
      routed(sel_n, 4'h6, PFM_FUNC_ALT1) & p[6];
    state_next.sense_reg.timer0_capture_2 =
      routed(sel_n, 4'h6, PFM_FUNC_ALT2) & p[6];
    state_next.sense_reg.spi_a_ssel_in =
      routed(sel_n, 4'h7, PFM_FUNC_ALT1) & p[7];
    // inputs of lines 9 and 10
    state_next.sense_reg.serial_b_receive =
      routed(sel_n, 4'h9, PFM_FUNC_ALT1) & p[9];
    state_next.sense_reg.ext_irq_line_3 =
      routed(sel_n, 4'h9, PFM_FUNC_ALT3) & p[9];
    state_next.sense_reg.timer1_capture_0 =
      routed(sel_n, 4'ha, PFM_FUNC_ALT2) & p[10];
    // inputs of lines 11 and 12
    state_next.sense_reg.serial_b_clear_to_send =
      routed(sel_n, 4'hb, PFM_FUNC_ALT1) & p[11];
    state_next.sense_reg.timer1_capture_1 =
      routed(sel_n, 4'hb, PFM_FUNC_ALT2) & p[11];
    state_next.sense_reg.serial_b_set_ready =
      routed(sel_n, 4'hc, PFM_FUNC_ALT1) & p[12];
    // inputs of lines 14 and 15
    state_next.sense_reg.serial_b_carrier_detect =
      routed(sel_n, 4'he, PFM_FUNC_ALT1) & p[14];
    state_next.sense_reg.serial_b_ring_indicator =
      routed(sel_n, 4'hf, PFM_FUNC_ALT1) & p[15];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg            <= '0;
      state_reg.select_reg <= PFM_SEL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o        = state_reg.rdata_reg;
  assign gpio_in_o      = state_reg.gpio_in_reg;
  assign periph_sense_o = state_reg.sense_reg;
  assign pad_out_o      = state_reg.pad_out_reg;
  assign pad_oe_o       = state_reg.pad_oe_reg;

endmodule // pfm_port0_low_mux

`default_nettype wire

// *** pkg/pfm_pkg.sv ***
// Package: constants and carriers of the port-zero low pin function mux
`default_nettype none

package pfm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] PFM_SEL_ADDR   = 32'he002c000;
  localparam logic [31:0] PFM_SEL_RESET  = 32'h00000000;
  localparam logic [31:0] PFM_READ_IDLE  = 32'h00000000;

  // ****************************************************************
  // Field layout and function codes
  // ****************************************************************
  localparam int          PFM_NUM_LINES  = 16;
  localparam int          PFM_FIELD_W    = 2;
  localparam logic [1:0]  PFM_FUNC_GPIO  = 2'h0;
  localparam logic [1:0]  PFM_FUNC_ALT1  = 2'h1;
  localparam logic [1:0]  PFM_FUNC_ALT2  = 2'h2;
  localparam logic [1:0]  PFM_FUNC_ALT3  = 2'h3;

  // Signals driven by on-chip peripherals towards the pins
  typedef struct packed {
    logic serial_a_transmit;
    logic pulse_out_1;
    logic pulse_out_2;
    logic pulse_out_3;
    logic pulse_out_4;
    logic pulse_out_6;
    logic i2c_scl_out;
    logic i2c_scl_oe;
    logic i2c_sda_out;
    logic i2c_sda_oe;
    logic spi_a_sck_out;
    logic spi_a_sck_oe;
    logic spi_a_miso_out;
    logic spi_a_miso_oe;
    logic spi_a_mosi_out;
    logic spi_a_mosi_oe;
    logic spi_a_ssel_out;
    logic spi_a_ssel_oe;
    logic timer0_match_0;
    logic timer0_match_1;
    logic serial_b_transmit;
    logic serial_b_request_to_send;
    logic serial_b_terminal_ready;
    logic timer1_match_0;
    logic timer1_match_1;
  } pfm_drive_type;

  // Pin levels handed to on-chip peripherals
  typedef struct packed {
    logic serial_a_receive;
    logic i2c_scl_in;
    logic i2c_sda_in;
    logic spi_a_sck_in;
    logic spi_a_miso_in;
    logic spi_a_mosi_in;
    logic spi_a_ssel_in;
    logic timer0_capture_0;
    logic timer0_capture_1;
    logic timer0_capture_2;
    logic ext_irq_line_0;
    logic ext_irq_line_1;
    logic ext_irq_line_2;
    logic ext_irq_line_3;
    logic serial_b_receive;
    logic serial_b_clear_to_send;
    logic serial_b_set_ready;
    logic serial_b_carrier_detect;
    logic serial_b_ring_indicator;
    logic timer1_capture_0;
    logic timer1_capture_1;
  } pfm_sense_type;

  // Whole state of the mux
  typedef struct packed {
    logic [31:0]   select_reg;
    logic [31:0]   rdata_reg;
    logic [15:0]   pad_meta_reg;
    logic [15:0]   pad_sync_reg;
    logic [15:0]   pad_out_reg;
    logic [15:0]   pad_oe_reg;
    logic [15:0]   gpio_in_reg;
    pfm_sense_type sense_reg;
  } pfm_state_type;

endpackage : pfm_pkg

`default_nettype wire

// *** verif/pfm_port0_low_mux_chk.sv ***
// Checker: timing and routing assertions of the pin function mux
`timescale 1ns/1ns
`default_nettype none

module pfm_port0_low_mux_chk
  import pfm_pkg::*;
(
  input wire logic          ref_clk_i,
  input wire logic          rst_i,
  input wire logic [31:0]   addr_i,
  input wire logic [31:0]   wdata_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic [31:0]   rdata_o,
  input wire logic [15:0]   gpio_out_i,
  input wire logic [15:0]   line_direction_control_i,
  input wire logic [15:0]   gpio_in_o,
  input wire pfm_drive_type periph_drive_i,
  input wire pfm_sense_type periph_sense_o,
  input wire logic [15:0]   pad_in_i,
  input wire logic [15:0]   pad_out_o,
  input wire logic [15:0]   pad_oe_o
);
  // ******
  // Shadow of the selector and settle counter
  // ******
  logic [31:0] shad;
  logic [15:0] dir_q;
  logic [15:0] out_q;
  logic [1:0]  up;
  logic        gpio_ok;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shad <= PFM_SEL_RESET;
      up   <= 2'h0;
    end else begin
      if (wr_i && addr_i == PFM_SEL_ADDR) shad <= wdata_i;
      if (up != 2'h3) up <= up + 2'h1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    dir_q <= line_direction_control_i;
    out_q <= gpio_out_i;
  end
  always_comb begin
    gpio_ok = 1'b1;
    for (int n = 0; n < 16; n++) begin
      if (shad[2*n +: 2] == PFM_FUNC_GPIO && (pad_oe_o[n] != dir_q[n] ||
          pad_out_o[n] != out_q[n])) gpio_ok = 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_data;
    rd_i && addr_i == PFM_SEL_ADDR |=> rdata_o == $past(shad);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("bad read data");
  property p_rd_idle;
    !(rd_i && addr_i == PFM_SEL_ADDR) |=> rdata_o == PFM_READ_IDLE;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray data");
  property p_gpio;
    up != 2'h0 |-> gpio_ok;
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio path wrong");
  property p_tx;
    up != 2'h0 && shad[1:0] == PFM_FUNC_ALT1 |-> pad_oe_o[0] &&
      pad_out_o[0] == $past(periph_drive_i.serial_a_transmit);
  endproperty
  a_tx: assert property (p_tx) else $error("line 0 transmit wrong");
  property p_scl;
    up != 2'h0 && shad[5:4] == PFM_FUNC_ALT1 |->
      pad_oe_o[2] == $past(periph_drive_i.i2c_scl_oe);
  endproperty
  a_scl: assert property (p_scl) else $error("line 2 enable wrong");
  property p_irq_in;
    shad[3:2] == PFM_FUNC_ALT3 |-> !pad_oe_o[1];
  endproperty
  a_irq_in: assert property (p_irq_in) else $error("input line drives");
  property p_sync;
    up == 2'h3 |-> gpio_in_o == $past(pad_in_i, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("pad input latency");
  property p_rx;
    up == 2'h3 && shad[3:2] == PFM_FUNC_ALT1 &&
      $past(shad[3:2], 3) == PFM_FUNC_ALT1 |->
      periph_sense_o.serial_a_receive == $past(pad_in_i[1], 3);
  endproperty
  a_rx: assert property (p_rx) else $error("line 1 receive wrong");
  property p_unrouted;
    shad[3:2] != PFM_FUNC_ALT1 && $past(shad[3:2]) != PFM_FUNC_ALT1 |->
      !periph_sense_o.serial_a_receive;
  endproperty
  a_unrouted: assert property (p_unrouted) else $error("unrouted input");
  c_rd: cover property (rd_i && addr_i == PFM_SEL_ADDR);
  c_scl: cover property (shad[5:4] == PFM_FUNC_ALT1);
  c_irq: cover property (shad[3:2] == PFM_FUNC_ALT3);
endmodule // pfm_port0_low_mux_chk

bind pfm_port0_low_mux pfm_port0_low_mux_chk pfm_port0_low_mux_chk_i (.*);

`default_nettype wire

// *** verif/tb_pfm_port0_low_mux.sv ***
// Testbench: register access and routing of the pin function mux
`timescale 1ns/1ns
`default_nettype none

module tb_pfm_port0_low_mux;
  import pfm_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [31:0]   addr = '0;
  logic [31:0]   wdata = '0;
  logic [31:0]   rdata;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  logic [15:0]   gout = '0;
  logic [15:0]   dir = '0;
  logic [15:0]   pin = '0;
  logic [15:0]   gin;
  logic [15:0]   pout;
  logic [15:0]   poe;
  pfm_drive_type drv = '0;
  pfm_sense_type sense;
  int            fail_count = 0;
  int            compares = 0;
  int            cycles = 0;
  logic [15:0]   oe_tab [4] = '{16'h0000, 16'h25fd, 16'h33ab, 16'h0075};
  logic [15:0]   out_tab [4] = '{16'h0000, 16'h25fd, 16'h33ab, 16'ha525};
  logic [31:0]   sel_tab [4] = '{32'h0, 32'h55555555, 32'haaaaaaaa,
                                 32'h000cc0cc};
  logic [20:0]   sn_tab [4] = '{21'h0, 21'h1fc07c, 21'h3b03, 21'h780};

  pfm_port0_low_mux pfm_port0_low_mux_i (
    .ref_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .gpio_out_i(gout),
    .line_direction_control_i(dir), .gpio_in_o(gin),
    .periph_drive_i(drv), .periph_sense_o(sense), .pad_in_i(pin),
    .pad_out_o(pout), .pad_oe_o(poe)
  );

  always #2 clk = ~clk;

  // Whole run is near 50 cycles, so this only trips on a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ******
  // Bus and compare tasks
  // ******
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [31:0] a, input logic [31:0] e,
                        input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask

  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(PFM_SEL_ADDR, PFM_SEL_RESET, "reset value");
    @(posedge clk);
    dir <= 16'h00ff;
    gout <= 16'ha5a5;
    pin <= '1;
    wr_reg(32'he002c004, 32'hffffffff);
    rd_reg(PFM_SEL_ADDR, PFM_SEL_RESET, "unmapped write");
    rd_reg(32'he002c004, 32'h0, "unmapped read");
    chk("gpio oe", 16'h00ff, poe);
    chk("gpio out", 16'ha5a5, pout);
    $display("test reset and gpio done");
    for (int c = 1; c < 4; c++) begin
      // Code 3 goes only to lines where it names a function
      wr_reg(PFM_SEL_ADDR, sel_tab[c]);
      if (c == 1) begin
        // Peripherals start driving only once routed
        @(posedge clk);
        drv <= '1;
      end
      rd_reg(PFM_SEL_ADDR, sel_tab[c], "select");
      chk("oe", oe_tab[c], poe);
      chk("out", out_tab[c], pout);
      // Extra edges cover the two-flop synchroniser
      repeat (3) @(posedge clk);
      #1;
      chk("sense", sn_tab[c], sense);
      chk("gpio in", 16'hffff, gin);
    end
    $display("test function codes done");
    @(posedge clk);
    drv <= '0;
    wr_reg(PFM_SEL_ADDR, 32'h55555555);
    chk("oe no drive", 16'h2501, poe);
    chk("out no drive", 16'h0000, pout);
    @(posedge clk);
    dir <= 16'hffff;
    gout <= 16'h0000;
    drv <= '1;
    wr_reg(PFM_SEL_ADDR, 32'h00000001);
    chk("iso oe", 16'hffff, poe);
    chk("iso out", 16'h0001, pout);
    wr_reg(PFM_SEL_ADDR, 32'h00000004);
    chk("iso oe 2", 16'hfffd, poe);
    $display("test field isolation done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd_reg(PFM_SEL_ADDR, PFM_SEL_RESET, "second reset");
    $display("test second reset done");
    end_of_test();
  end
endmodule // tb_pfm_port0_low_mux

`default_nettype wire
